/* verilog/cfsa_top.sv */
`timescale 1ns/1ps
`include "cfsa_map.svh"
// Functional notes
// - pack configuration word stored at subclass 64 offset 0.
// - converter ground pin picked by ground-select bit, default main ground.
// - current wake bits default 0, 0 and 1.
// - with clear-on-read set, reading the high fault flag byte clears them.
// - alert polarity one idles low; zero idles high.
// - sleep, reload, thermistor and resistance step bits default to one.
// - algorithm enable byte stored at subclass 64 offset 2.
// - second configuration byte stored at subclass 64 offset 3.
// - two mode bits pick the multi-function pin function.
// - switches take their initial-state bits at reset.
// - sleep accumulation bit picks 10 s instead of 20 s.
// - alert enable word at offset 4, enabled faults ORed onto alert.
// - stored alert enables load at restart; runtime mask by command.
// - unsealed with control zero: class then offset maps storage block.
// - block commits to storage only after a matching checksum.
// - sealed or nonzero control: offset 1..3 loads info block A..C.
// - sealed hides general storage, A read-only, B and C writable.
// - keys writable only in full-access mode.
// - each key transition needs its own two control words back to back; sealing takes one.
// - sealed bit clears on unseal keys, full-access bit on full keys.
module cfsa_top
    import cfsa_pkg::*;
#(
    parameter cfsa_mode_t  INIT_MODE  = cfsa_pkg::MODE_SEALED,
    parameter logic [31:0] UNSEAL_KEY = 32'h5A3C9617,
    parameter logic [31:0] FULL_KEY   = 32'hC3A5E10F
) (
    // clock and resets
    input  wire logic              I_MCLK,
    input  wire logic              I_SRST,
    input  wire logic              I_POR,
    // command link
    input  wire logic              I_LINK_CLK,
    input  wire logic              I_LINK_WR,
    input  wire logic [7:0]        I_LINK_ADDR,
    input  wire logic [7:0]        I_LINK_WDATA,
    output logic [7:0]             O_LINK_RDATA,
    // gauge and protection side
    input  wire logic [15:0]       I_FAULT,
    input  wire logic              I_SW_SET_VALID,
    input  wire logic [1:0]        I_SW_SET,
    // configuration outputs
    output cfsa_pkg::cfsa_cfg_t    O_CFG,
    output cfsa_pkg::cfsa_mode_t   O_MODE,
    output logic                   O_ADC_GND_SEL,
    output logic [4:0]             O_SLEEP_ACCUM_S,
    output logic                   O_CHG_SW,
    output logic                   O_DSG_SW,
    output logic                   O_MPIN,
    output logic                   O_MPIN_OE
);
    import cfsa_pkg::*;

    // ************************************************************
    // link sampling
    // ************************************************************
    wire logic          rst = I_SRST | I_POR;
    logic [17:0]        raw;
    logic [18:0]        sy1_q, sy2_q, sy3_q;
    logic               lclk_q;
    cfsa_link_t         lk;
    logic               cmd_stb, wr_stb, rd_stb;

    assign raw = {I_LINK_WR, I_LINK_ADDR, I_LINK_WDATA};
    always_ff @(posedge I_MCLK) begin
        if (rst) begin
            sy1_q <= 19'h0;
            sy2_q <= 19'h0;
            sy3_q <= 19'h0;
        end else begin
            sy1_q <= {I_LINK_CLK, raw};
            sy2_q <= sy1_q;
            sy3_q <= sy2_q;
        end
    end
    // a link edge counts only once two stages agree, rejecting glitches
    always_ff @(posedge I_MCLK) begin
        if (rst) begin
            lclk_q <= 1'b0;
        end else if (sy2_q[18] == sy3_q[18]) begin
            lclk_q <= sy3_q[18];
        end
    end
    assign cmd_stb = sy2_q[18] & sy3_q[18] & ~lclk_q;
    assign lk      = cfsa_link_t'(sy3_q[17:0]);
    assign wr_stb  = cmd_stb & lk.wr;
    assign rd_stb  = cmd_stb & ~lk.wr;

    // ************************************************************
    // command decode
    // ************************************************************
    wire logic is_ctrl_lo = lk.addr == `CFSA_CMD_CTRL_LO;
    wire logic is_ctrl_hi = lk.addr == `CFSA_CMD_CTRL_HI;
    wire logic is_class   = lk.addr == `CFSA_CMD_CLASS;
    wire logic is_ofs     = lk.addr == `CFSA_CMD_BLKOFS;
    wire logic is_win     = (lk.addr >= `CFSA_CMD_WIN_BASE) &&
                            (lk.addr <= `CFSA_CMD_WIN_LAST);
    wire logic is_ck      = lk.addr == `CFSA_CMD_CKSUM;
    wire logic is_bctl    = lk.addr == `CFSA_CMD_BLKCTL;
    wire logic is_am_lo   = lk.addr == `CFSA_CMD_AMASK_LO;
    wire logic is_am_hi   = lk.addr == `CFSA_CMD_AMASK_HI;
    wire logic is_fl_lo   = lk.addr == `CFSA_CMD_FLAG_LO;
    wire logic is_fl_hi   = lk.addr == `CFSA_CMD_FLAG_HI;

    // ************************************************************
    // storage
    // ************************************************************
    logic [7:0]   nv_q  [0:4][0:31];
    logic [7:0]   buf_q [0:31];
    cfsa_mode_t   mode_q, mode_d;
    logic [7:0]   bctl_q, class_q, ctrl_lo_q;
    logic [2:0]   bank_q, sel_bank;
    logic         sealed, general_path, can_rd, can_wr, ck_ok, commit;

    function automatic logic [7:0] def_byte(input int b, input int i);
        logic [7:0] v;
        v = 8'h00;
        if (b == int'(`CFSA_BANK_CFG)) begin
            if (i == int'(`CFSA_OFS_PACK))
                v = 8'(`CFSA_DEF_PACK >> 8);
            if (i == int'(`CFSA_OFS_PACK) + 1)
                v = 8'(`CFSA_DEF_PACK);
            if (i == int'(`CFSA_OFS_CFG_B)) v = `CFSA_DEF_CFG_B;
            if (i == int'(`CFSA_OFS_CFG_C)) v = `CFSA_DEF_CFG_C;
            if (i == int'(`CFSA_OFS_ALERT))
                v = 8'(`CFSA_DEF_ALERT >> 8);
            if (i == int'(`CFSA_OFS_ALERT) + 1)
                v = 8'(`CFSA_DEF_ALERT);
        end else if (b == int'(`CFSA_BANK_KEY) && i < 8) begin
            v = (i < 4) ? UNSEAL_KEY[8*(3-i) +: 8] : FULL_KEY[8*(7-i) +: 8];
        end
        return v;
    endfunction

    function automatic logic [7:0] buf_sum();
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 32; i++) begin
            s = s + buf_q[i];
        end
        return s;
    endfunction

    function automatic logic [2:0] gen_bank(input logic [7:0] cls,
                                            input logic [7:0] ofs);
        logic [2:0] b;
        b = `CFSA_BANK_NONE;
        if (cls == `CFSA_SUB_CFG && ofs == 8'h00) b = `CFSA_BANK_CFG;
        else if (cls == `CFSA_SUB_INFO && ofs <= 8'h02)
            b = ofs[2:0] + `CFSA_BANK_A;
        else if (cls == `CFSA_SUB_KEY && ofs == 8'h00) b = `CFSA_BANK_KEY;
        return b;
    endfunction

    function automatic logic [15:0] nv_word(input int b, input logic [4:0] o);
        return {nv_q[b][o], nv_q[b][o + 5'd1]};
    endfunction

    assign sealed       = mode_q == MODE_SEALED;
    assign general_path = ~sealed && bctl_q == `CFSA_BLKCTL_GEN;
    // info select codes 1..3 map straight onto banks A..C
    assign sel_bank = general_path ? gen_bank(class_q, lk.wdata) :
                      (lk.wdata >= `CFSA_SEL_INFO_A &&
                       lk.wdata <= `CFSA_SEL_INFO_C) ?
                      lk.wdata[2:0] : `CFSA_BANK_NONE;
    // configuration and key banks chosen before sealing stay hidden once sealed; banks A..C stay readable
    assign can_rd = (bank_q <= `CFSA_BANK_KEY) &&
                    (~sealed || (bank_q >= `CFSA_BANK_A &&
                                 bank_q <= `CFSA_BANK_C));
    assign can_wr = can_rd && ~(sealed && bank_q == `CFSA_BANK_A) &&
                    (bank_q != `CFSA_BANK_KEY || mode_q == MODE_FULL);
    // a process, so the sum follows every buffer edit, not only the byte
    always_comb ck_ok = lk.wdata == ~buf_sum();
    assign commit = wr_stb && is_ck && can_wr && ck_ok;

    // nonvolatile contents survive the device reset; only power-on reloads
    always_ff @(posedge I_MCLK) begin
        if (I_POR) begin
            for (int b = 0; b < 5; b++) begin
                for (int i = 0; i < 32; i++) begin
                    nv_q[b][i] <= def_byte(b, i);
                end
            end
        end else if (commit) begin
            for (int i = 0; i < 32; i++) begin
                nv_q[bank_q][i] <= buf_q[i];
            end
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (rst) begin
            bank_q <= `CFSA_BANK_NONE;
            for (int i = 0; i < 32; i++) begin
                buf_q[i] <= 8'h00;
            end
        end else if (wr_stb && is_ofs) begin
            bank_q <= sel_bank;
            for (int i = 0; i < 32; i++) begin
                buf_q[i] <= (sel_bank <= `CFSA_BANK_KEY) ?
                            nv_q[sel_bank][i] : 8'h00;
            end
        end else if (wr_stb && is_win && can_wr) begin
            buf_q[lk.addr[4:0]] <= lk.wdata;
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (rst) begin
            bctl_q    <= 8'h00;
            class_q   <= 8'h00;
            ctrl_lo_q <= 8'h00;
        end else if (wr_stb) begin
            if (is_bctl) bctl_q <= lk.wdata;
            if (is_class) class_q <= lk.wdata;
            if (is_ctrl_lo) ctrl_lo_q <= lk.wdata;
        end
    end

    // ************************************************************
    // security modes
    // ************************************************************
    logic         pend_q;
    logic [15:0]  pend_word_q;
    wire logic        ctrl_wr   = wr_stb & is_ctrl_hi;
    wire logic [15:0] ctrl_word = {lk.wdata, ctrl_lo_q};
    // host sends word 1 first, byte-swapped against the stored order
    wire logic [15:0] us_w1 = {nv_q[4][`CFSA_KEY_US + 5'd3],
                               nv_q[4][`CFSA_KEY_US + 5'd2]};
    wire logic [15:0] us_w0 = {nv_q[4][`CFSA_KEY_US + 5'd1],
                               nv_q[4][`CFSA_KEY_US]};
    wire logic [15:0] fa_w1 = {nv_q[4][`CFSA_KEY_FA + 5'd3],
                               nv_q[4][`CFSA_KEY_FA + 5'd2]};
    wire logic [15:0] fa_w0 = {nv_q[4][`CFSA_KEY_FA + 5'd1],
                               nv_q[4][`CFSA_KEY_FA]};
    // subcommands never open a key sequence; key codes must avoid them
    wire logic is_first = ctrl_word == us_w1 || ctrl_word == fa_w1;
    wire logic us_ok = pend_q && pend_word_q == us_w1 && ctrl_word == us_w0;
    wire logic fa_ok = pend_q && pend_word_q == fa_w1 && ctrl_word == fa_w0;
    wire logic seal_cmd = ~pend_q && ctrl_word == `CFSA_SUBCMD_SEAL;
    wire logic [15:0] status = (16'(sealed) << `CFSA_SS_BIT) |
                               (16'(mode_q != MODE_FULL) << `CFSA_FAS_BIT);

    always_ff @(posedge I_MCLK) begin
        if (rst) begin
            pend_q      <= 1'b0;
            pend_word_q <= 16'h0000;
        end else if (ctrl_wr) begin
            pend_q      <= ~pend_q && is_first;
            pend_word_q <= ctrl_word;
        end
    end

    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            MODE_SEALED: begin
                if (ctrl_wr && us_ok) mode_d = MODE_UNSEALED;
            end
            MODE_UNSEALED: begin
                if (ctrl_wr && fa_ok) mode_d = MODE_FULL;
                else if (ctrl_wr && seal_cmd) mode_d = MODE_SEALED;
            end
            MODE_FULL: begin
                if (ctrl_wr && seal_cmd) mode_d = MODE_SEALED;
            end
            default: mode_d = MODE_SEALED;
        endcase
    end

    always_ff @(posedge I_MCLK) begin
        if (rst) mode_q <= INIT_MODE;
        else mode_q <= mode_d;
    end

    // ************************************************************
    // active configuration, alert and switches
    // ************************************************************
    cfsa_cfg_t    act_q;
    logic [15:0]  amask_q, fault_q;
    logic         alert_q, chg_q, dsg_q;
    wire logic    clr_rd   = act_q.pack[`CFSA_B_CLRRD];
    wire logic    pol      = act_q.pack[`CFSA_B_POL];
    wire logic [1:0] pmode = act_q.cfg_c[`CFSA_C_PIN_HI:`CFSA_C_PIN_LO];
    wire logic    alert_act = |(fault_q & amask_q);
    wire logic    fl_clear = rd_stb && is_fl_hi && clr_rd;
    wire logic [7:0] nv_c  = nv_q[0][`CFSA_OFS_CFG_C];

    // stored configuration only takes effect at a restart
    always_ff @(posedge I_MCLK) begin
        if (I_POR) begin
            act_q   <= {`CFSA_DEF_PACK, `CFSA_DEF_CFG_B, `CFSA_DEF_CFG_C,
                        `CFSA_DEF_ALERT};
            amask_q <= `CFSA_DEF_ALERT & `CFSA_ALERT_VALID;
        end else if (I_SRST) begin
            act_q   <= {nv_word(0, `CFSA_OFS_PACK), nv_q[0][`CFSA_OFS_CFG_B],
                        nv_c, nv_word(0, `CFSA_OFS_ALERT)};
            amask_q <= nv_word(0, `CFSA_OFS_ALERT) & `CFSA_ALERT_VALID;
        end else if (wr_stb && is_am_lo) begin
            amask_q[7:0] <= lk.wdata & 8'(`CFSA_ALERT_VALID);
        end else if (wr_stb && is_am_hi) begin
            amask_q[15:8] <= lk.wdata & 8'(`CFSA_ALERT_VALID >> 8);
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (rst) begin
            fault_q <= 16'h0000;
            alert_q <= 1'b0;
        end else begin
            // a fault arriving with the clearing read still latches
            fault_q <= clr_rd ? ((fl_clear ? 16'h0000 : fault_q) | I_FAULT)
                              : I_FAULT;
            alert_q <= pol ? alert_act : ~alert_act;
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (I_POR) begin
            chg_q <= 1'(`CFSA_DEF_CFG_C >> `CFSA_C_CHG_INIT);
            dsg_q <= 1'(`CFSA_DEF_CFG_C >> `CFSA_C_DSG_INIT);
        end else if (I_SRST) begin
            chg_q <= nv_c[`CFSA_C_CHG_INIT];
            dsg_q <= nv_c[`CFSA_C_DSG_INIT];
        end else if (I_SW_SET_VALID) begin
            chg_q <= I_SW_SET[1];
            dsg_q <= I_SW_SET[0];
        end
    end

    assign O_CFG          = act_q;
    assign O_MODE         = mode_q;
    assign O_ADC_GND_SEL  = act_q.pack[`CFSA_B_ADC_GROUND_SELECT];
    assign O_SLEEP_ACCUM_S = act_q.cfg_c[`CFSA_C_SLEEPCHG] ?
                             `CFSA_ACCUM_FAST_S : `CFSA_ACCUM_SLOW_S;
    assign O_CHG_SW       = chg_q;
    assign O_DSG_SW       = dsg_q;
    // single-wire mode leaves the pin undriven; reserved mode too
    assign O_MPIN_OE = pmode == `CFSA_PIN_CHGSW || pmode == `CFSA_PIN_ALERT;
    assign O_MPIN    = (pmode == `CFSA_PIN_CHGSW) ? chg_q :
                       (pmode == `CFSA_PIN_ALERT) ? alert_q : 1'b0;

    // ************************************************************
    // read data
    // ************************************************************
    logic [7:0] rd_byte, rdata_q;
    always_comb begin
        rd_byte = 8'h00;
        if (is_ctrl_lo) rd_byte = status[7:0];
        else if (is_ctrl_hi) rd_byte = status[15:8];
        else if (is_class) rd_byte = class_q;
        else if (is_bctl) rd_byte = bctl_q;
        else if (is_win) rd_byte = can_rd ? buf_q[lk.addr[4:0]] : 8'h00;
        else if (is_ck) rd_byte = ~buf_sum();
        else if (is_am_lo) rd_byte = amask_q[7:0];
        else if (is_am_hi) rd_byte = amask_q[15:8];
        else if (is_fl_lo) rd_byte = fault_q[7:0];
        else if (is_fl_hi) rd_byte = fault_q[15:8];
    end
    always_ff @(posedge I_MCLK) begin
        if (rst) rdata_q <= 8'h00;
        else if (rd_stb) rdata_q <= rd_byte;
    end
    assign O_LINK_RDATA = rdata_q;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (rst);
    sequence seq_us_pair;
        ctrl_wr && us_ok && mode_q == MODE_SEALED;
    endsequence
    sequence seq_fa_pair;
        ctrl_wr && fa_ok && mode_q == MODE_UNSEALED;
    endsequence
    a_unseal_pair: assert property (seq_us_pair |=>
        mode_q == MODE_UNSEALED && !status[`CFSA_SS_BIT])
        else $error("unseal pair did not unseal");
    a_full_pair: assert property (seq_fa_pair |=>
        mode_q == MODE_FULL && !status[`CFSA_FAS_BIT])
        else $error("full access pair did not grant access");
    a_bad_pair_kept: assert property (ctrl_wr && pend_q && !us_ok &&
        !fa_ok |=> $stable(mode_q) && !pend_q)
        else $error("failed key pair changed mode");
    a_block_a_locked: assert property (wr_stb && is_ck && sealed &&
        bank_q == `CFSA_BANK_A |=> $stable(nv_q[1][0]))
        else $error("sealed write reached block A");
    a_key_write_full: assert property (wr_stb && is_ck &&
        mode_q != MODE_FULL && bank_q == `CFSA_BANK_KEY |=>
        $stable(nv_q[4][0]))
        else $error("key bank written outside full access");
    a_bad_cksum_kept: assert property (wr_stb && is_ck && !ck_ok &&
        bank_q == `CFSA_BANK_CFG |=> $stable(nv_q[0][3]))
        else $error("bad checksum committed block");
    a_info_load: assert property (wr_stb && is_ofs && !general_path &&
        lk.wdata == `CFSA_SEL_INFO_B |=> bank_q == `CFSA_BANK_B &&
        buf_q[0] == nv_q[2][0])
        else $error("info block not loaded");
    a_alert_level: assert property (pmode == `CFSA_PIN_ALERT &&
        !$past(rst) |-> O_MPIN == ($past(alert_act) ? pol : !pol))
        else $error("alert level wrong for polarity");
    a_flag_clear: assert property (fl_clear |=>
        fault_q == $past(I_FAULT))
        else $error("clear on read did not clear flags");
    a_flag_follow: assert property (!clr_rd |=>
        fault_q == $past(I_FAULT))
        else $error("flags not tracking faults");
    a_switch_init: assert property ($past(I_SRST) && !$past(I_POR) &&
        !$past(I_SW_SET_VALID, 1) |-> O_CHG_SW ==
        $past(nv_c[`CFSA_C_CHG_INIT]) && O_DSG_SW ==
        $past(nv_c[`CFSA_C_DSG_INIT]))
        else $error("switches not at initial state");
endmodule

/* verilog/cfsa_map.svh */
`ifndef CFSA_MAP_SVH
`define CFSA_MAP_SVH
// ****************************************************************
// command space
// ****************************************************************
`define CFSA_CMD_CTRL_LO   8'h00
`define CFSA_CMD_CTRL_HI   8'h01
`define CFSA_CMD_CLASS     8'h3E
`define CFSA_CMD_BLKOFS    8'h3F
`define CFSA_CMD_WIN_BASE  8'h40
`define CFSA_CMD_WIN_LAST  8'h5F
`define CFSA_CMD_CKSUM     8'h60
`define CFSA_CMD_BLKCTL    8'h61
`define CFSA_CMD_AMASK_LO  8'h6E
`define CFSA_CMD_AMASK_HI  8'h6F
`define CFSA_CMD_FLAG_LO   8'h70
`define CFSA_CMD_FLAG_HI   8'h71
`define CFSA_BLKCTL_GEN    8'h00
`define CFSA_SEL_INFO_A    8'h01
`define CFSA_SEL_INFO_B    8'h02
`define CFSA_SEL_INFO_C    8'h03
`define CFSA_SUBCMD_SEAL   16'h0020
`define CFSA_SS_BIT        13
`define CFSA_FAS_BIT       14
// ****************************************************************
// storage subclasses, banks and offsets
// ****************************************************************
`define CFSA_SUB_CFG       8'h40
`define CFSA_SUB_INFO      8'h3A
`define CFSA_SUB_KEY       8'h70
`define CFSA_BANK_CFG      3'h0
`define CFSA_BANK_A        3'h1
`define CFSA_BANK_B        3'h2
`define CFSA_BANK_C        3'h3
`define CFSA_BANK_KEY      3'h4
`define CFSA_BANK_NONE     3'h7
`define CFSA_OFS_PACK      5'h00
`define CFSA_OFS_CFG_B     5'h02
`define CFSA_OFS_CFG_C     5'h03
`define CFSA_OFS_ALERT     5'h04
`define CFSA_KEY_US        5'h00
`define CFSA_KEY_FA        5'h04
// ****************************************************************
// field positions and defaults
// ****************************************************************
`define CFSA_DEF_PACK      16'h0171
`define CFSA_DEF_CFG_B     8'hFD
`define CFSA_DEF_CFG_C     8'h03
`define CFSA_DEF_ALERT     16'h0000
`define CFSA_ALERT_VALID   16'hC0F7
`define CFSA_B_ADC_GROUND_SELECT      7
`define CFSA_B_CLRRD       3
`define CFSA_B_POL         2
`define CFSA_C_PIN_HI      5
`define CFSA_C_PIN_LO      4
`define CFSA_C_SLEEPCHG    3
`define CFSA_C_CHG_INIT    1
`define CFSA_C_DSG_INIT    0
`define CFSA_PIN_CHGSW     2'h1
`define CFSA_PIN_ALERT     2'h2
`define CFSA_ACCUM_FAST_S  5'h0A
`define CFSA_ACCUM_SLOW_S  5'h14
`endif

/* verilog/cfsa_pkg.sv */
package cfsa_pkg;
    typedef enum logic [1:0] {
        MODE_SEALED   = 2'b00,
        MODE_UNSEALED = 2'b01,
        MODE_FULL     = 2'b11
    } cfsa_mode_t;
    typedef struct packed {
        logic [15:0] pack;
        logic [7:0]  cfg_b;
        logic [7:0]  cfg_c;
        logic [15:0] alert_en;
    } cfsa_cfg_t;
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cfsa_link_t;
endpackage

/* sim/cfsa_host.sv */
`timescale 1ns/1ps
// ****************************************************************
// host side of the command link
// ****************************************************************
module cfsa_host (
    // clock and read back
    input  wire logic       i_clk,
    input  wire logic [7:0] i_rdata,
    // link towards the device
    output logic            o_link_clk,
    output logic            o_wr,
    output logic [7:0]      o_addr,
    output logic [7:0]      o_wdata
);
    initial begin
        o_link_clk = 1'b0;
        o_wr = 1'b0;
        o_addr = 8'hFF;
        o_wdata = 8'h00;
    end
    // strobe rises mid field hold: six clocks of setup and hold each side
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q);
        @(posedge i_clk);
        o_wr <= w;
        o_addr <= a;
        o_wdata <= d;
        #62.5 o_link_clk = 1'b1;
        #62.5 o_link_clk = 1'b0;
        #62.5;
        @(posedge i_clk);
        q = i_rdata;
        // released fields never show the last value
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask
endmodule

/* sim/tb_cfsa_top.sv */
`timescale 1ns/1ps
`include "cfsa_map.svh"
module tb_cfsa_top;
    import cfsa_pkg::*;
    logic        clk = 0, srst = 1, por = 1, sw_v = 0;
    logic [1:0]  sw = 2'b11;
    logic [15:0] fault = 16'h0000;
    logic        lclk, wr, gnd, chg, dsg, mpin, oe;
    logic [7:0]  addr, wdata, rdata, q;
    logic [4:0]  accum;
    cfsa_cfg_t   cfg;
    cfsa_mode_t  mode;
    int          err_total = 0, cmp_count = 0;
    always #5 clk = ~clk;
    cfsa_host cfsa_host_i (.i_clk(clk), .i_rdata(rdata), .o_link_clk(lclk),
        .o_wr(wr), .o_addr(addr), .o_wdata(wdata));
    cfsa_top cfsa_top_i (.I_MCLK(clk), .I_SRST(srst), .I_POR(por),
        .I_LINK_CLK(lclk), .I_LINK_WR(wr), .I_LINK_ADDR(addr),
        .I_LINK_WDATA(wdata), .O_LINK_RDATA(rdata), .I_FAULT(fault),
        .I_SW_SET_VALID(sw_v), .I_SW_SET(sw), .O_CFG(cfg), .O_MODE(mode),
        .O_ADC_GND_SEL(gnd), .O_SLEEP_ACCUM_S(accum), .O_CHG_SW(chg),
        .O_DSG_SW(dsg), .O_MPIN(mpin), .O_MPIN_OE(oe));
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic [7:0] a, input logic [7:0] d);
        cfsa_host_i.xfer(1'b1, a, d, q);
    endtask
    task automatic rb(input logic [7:0] a);
        cfsa_host_i.xfer(1'b0, a, 8'h00, q);
    endtask
    // both halves of a control word, low byte first
    task automatic ctrl(input logic [15:0] w);
        wb(`CFSA_CMD_CTRL_LO, w[7:0]);
        wb(`CFSA_CMD_CTRL_HI, w[15:8]);
    endtask
    task automatic restart(input int n);
        @(posedge clk);
        srst <= 1'b1;
        repeat (n) @(posedge clk);
        srst <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic t_defaults();
        chk(cfg, {16'h0171, 8'hFD, 8'h03, 16'h0000});
        chk({gnd, accum, chg, dsg, oe}, {1'b0, 5'd20, 3'b110});
        chk(mode, MODE_SEALED);
        rb(`CFSA_CMD_CTRL_HI);
        chk(q[6:5], 2'b11);
        @(posedge clk);
        sw <= 2'b00;
        sw_v <= 1'b1;
        @(posedge clk);
        sw_v <= 1'b0;
        @(posedge clk);
        chk({chg, dsg}, 2'b00);
    endtask
    // words byte-swapped, key word 1 sent first
    task automatic t_keys();
        ctrl(16'h1796);
        ctrl(16'h1234);
        chk(mode, MODE_SEALED);
        ctrl(16'h1796);
        ctrl(16'h3C5A);
        chk(mode, MODE_UNSEALED);
        rb(`CFSA_CMD_CTRL_HI);
        chk(q[5], 1'b0);
        ctrl(16'h0FE1);
        ctrl(16'hA5C3);
        chk(mode, MODE_FULL);
        rb(`CFSA_CMD_CTRL_HI);
        chk(q[6], 1'b0);
    endtask
    task automatic t_store();
        wb(`CFSA_CMD_BLKCTL, `CFSA_BLKCTL_GEN);
        wb(`CFSA_CMD_CLASS, `CFSA_SUB_CFG);
        wb(`CFSA_CMD_BLKOFS, 8'h00);
        rb(8'h43);
        chk(q, 8'h03);
        wb(8'h43, 8'h29);
        wb(`CFSA_CMD_CKSUM, 8'h66);
        wb(`CFSA_CMD_BLKOFS, 8'h00);
        rb(8'h43);
        chk(q, 8'h03);
        wb(8'h41, 8'hF9);
        wb(8'h43, 8'h29);
        wb(`CFSA_CMD_CKSUM, 8'hDF);
        wb(`CFSA_CMD_BLKOFS, 8'h00);
        rb(8'h43);
        chk(q, 8'h29);
        chk(cfg.cfg_c, 8'h03);
        restart(2);
        chk(cfg.pack, 16'h01F9);
        chk(cfg.cfg_c, 8'h29);
        chk({gnd, accum, chg, dsg, oe, mpin}, {6'h2A, 4'b0111});
        wb(`CFSA_CMD_AMASK_LO, 8'h01);
        @(posedge clk);
        fault <= 16'h0001;
        repeat (4) @(posedge clk);
        chk(mpin, 1'b0);
        fault <= 16'h0000;
        // flags stay latched until the high byte is read
        rb(`CFSA_CMD_FLAG_LO);
        chk(q, 8'h01);
        rb(`CFSA_CMD_FLAG_HI);
        rb(`CFSA_CMD_FLAG_LO);
        chk({q, mpin}, 9'h001);
        ctrl(16'h1796);
        ctrl(16'h3C5A);
        chk(mode, MODE_UNSEALED);
        // unsealed may read the key bank but not edit it
        wb(`CFSA_CMD_CLASS, `CFSA_SUB_KEY);
        wb(`CFSA_CMD_BLKOFS, 8'h00);
        wb(8'h40, 8'h00);
        wb(`CFSA_CMD_CKSUM, 8'hBE);
        wb(`CFSA_CMD_BLKOFS, 8'h00);
        rb(8'h40);
        chk(q, 8'h5A);
        wb(`CFSA_CMD_CLASS, `CFSA_SUB_CFG);
        wb(`CFSA_CMD_BLKOFS, 8'h00);
        wb(8'h43, 8'h19);
        wb(`CFSA_CMD_CKSUM, 8'hEF);
        ctrl(`CFSA_SUBCMD_SEAL);
        chk(mode, MODE_SEALED);
        restart(2);
        chk({chg, dsg, oe, mpin}, 4'b0110);
        @(posedge clk);
        sw <= 2'b10;
        sw_v <= 1'b1;
        @(posedge clk);
        sw_v <= 1'b0;
        @(posedge clk);
        chk({chg, dsg, oe, mpin}, 4'b1011);
    endtask
    // sealed: block A refuses edits, block B keeps them
    task automatic t_sealed();
        for (int b = 2; b > 0; b--) begin
            wb(`CFSA_CMD_BLKOFS, 8'(b));
            wb(8'h40, 8'h5A);
            wb(`CFSA_CMD_CKSUM, 8'hA5);
        end
        wb(`CFSA_CMD_BLKOFS, `CFSA_SEL_INFO_A);
        rb(8'h40);
        chk(q, 8'h00);
        wb(`CFSA_CMD_BLKOFS, `CFSA_SEL_INFO_B);
        rb(8'h40);
        chk(q, 8'h5A);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        por <= 1'b0;
        srst <= 1'b0;
        repeat (3) @(posedge clk);
        t_defaults();
        t_keys();
        t_store();
        t_sealed();
        tally_and_finish();
    end
    // some sixty transfers of about 20 clocks each, with ample margin
    initial begin
        #200000;
        err_total++;
        tally_and_finish();
    end
endmodule
